// file: inc/tcu_map.vh
/*
 * Register offsets, field positions, count limits and mode codes for the
 * 8-bit timer with two compare channels. Assumes a 32-bit APB master
 * that uses word-aligned byte addresses.
 */
`ifndef TCU_MAP_VH
`define TCU_MAP_VH

`define TCU_ADDR_CTRL_A   12'h000
`define TCU_ADDR_CTRL_B   12'h004
`define TCU_ADDR_COUNT    12'h008
`define TCU_ADDR_CMP_A    12'h00c
`define TCU_ADDR_CMP_B    12'h010
`define TCU_ADDR_FLAGS    12'h014
`define TCU_ADDR_MASK     12'h018
`define TCU_ADDR_OUT      12'h01c

`define TCU_CA_WGM_LO     1:0
`define TCU_CA_COMB       5:4
`define TCU_CA_COMA       7:6
`define TCU_CB_CS         2:0
`define TCU_CB_WGM_HI     3
`define TCU_CB_FORCE_B    6
`define TCU_CB_FORCE_A    7
`define TCU_FL_OVF        0
`define TCU_FL_MA         1
`define TCU_FL_MB         2

`define TCU_BOTTOM        8'h00
`define TCU_MAX           8'hff
`define TCU_CS_STOP       3'h0

`define TCU_WGM_NORMAL    3'h0
`define TCU_WGM_PC_MAX    3'h1
`define TCU_WGM_CTC       3'h2
`define TCU_WGM_FAST_MAX  3'h3
`define TCU_WGM_PC_TOP    3'h5
`define TCU_WGM_FAST_TOP  3'h7

`define TCU_COM_OFF       2'h0
`define TCU_COM_TOGGLE    2'h1
`define TCU_COM_CLEAR     2'h2
`define TCU_COM_SET       2'h3

`endif

// file: verif/tcu_isr_model.sv
/*
 * Interrupt service model standing in for the CPU core.
 * Assumes level requests; services them after DLY cycles when enabled.
 */
module tcu_isr_model #(
    parameter DLY = 3
) (
    input  logic       pclk,
    input  logic       presetn,
    input  logic       svc_on,
    input  logic [2:0] irq,
    output logic [2:0] ack
);
    timeunit 1ns;
    timeprecision 1ns;
    int wait_r;
    // A slow handler; DLY above one keeps a falling request from re-entry.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 0;
            ack    <= 3'h0;
        end else begin
            ack <= 3'h0;
            if (svc_on && irq != 3'h0 && wait_r >= DLY) begin
                ack    <= irq;
                wait_r <= 0;
            end else if (svc_on && irq != 3'h0)
                wait_r <= wait_r + 1;
            else
                wait_r <= 0;
        end
    end
endmodule

// file: verif/tcu_timer8_chk.sv
/*
 * Port checker for the 8-bit timer with two compare channels.
 * Assumes pclk at 50 MHz and presetn asynchronous, active low.
 */
module tcu_timer8_chk #(
    parameter AW = 12
) (
    input logic          pclk,
    input logic          presetn,
    input logic          psel,
    input logic          penable,
    input logic          pwrite,
    input logic [AW-1:0] paddr,
    input logic [31:0]   pwdata,
    input logic          pready,
    input logic          pslverr,
    input logic          tick_in,
    input logic          irq_ack_ovf,
    input logic          irq_ovf,
    input logic          irq_a,
    input logic          port_data_b,
    input logic          pin_out_a,
    input logic          pin_out_b,
    input logic          timer_active
);
    timeunit 1ns;
    timeprecision 1ns;
    wire       wr_done = psel && penable && pwrite && pready;
    wire [2:0] cs_wr   = pwdata[2:0];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_cs_write;
        wr_done && paddr == 12'h004;
    endsequence
    chk_ready_answer: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_never_error: assert property (pslverr == 1'b0)
        else $error("error response seen");
    chk_active_cs: assert property (s_cs_write |-> ##2
        timer_active == ($past(cs_wr, 2) != 3'h0))
        else $error("active flag disagrees with clock select");
    chk_ack_clears: assert property (irq_ack_ovf && !tick_in |-> ##2
        !irq_ovf) else $error("serviced interrupt still raised");
    chk_irq_cause: assert property ($rose(irq_a) |->
        $past(tick_in, 2) || $past(wr_done, 2))
        else $error("interrupt rose without tick or write");
    chk_reset_clear: assert property ($rose(presetn) |->
        !pin_out_a && !pin_out_b && !irq_ovf)
        else $error("outputs not clear after reset");
    chk_pin_quiet: assert property ($changed(pin_out_b) |->
        $past(port_data_b) != $past(port_data_b, 2) || $past(tick_in)
        || $past(tick_in, 2) || $past(wr_done) || $past(wr_done, 2)
        || !$past(presetn, 3)) else $error("pin changed without cause");
endmodule

bind tcu_timer8 tcu_timer8_chk #(.AW(AW)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .tick_in(tick_in), .irq_ack_ovf(irq_ack_ovf),
    .irq_ovf(irq_ovf), .irq_a(irq_a), .port_data_b(port_data_b),
    .pin_out_a(pin_out_a), .pin_out_b(pin_out_b),
    .timer_active(timer_active)
);

// file: verif/test_timer8_compare_output_unit.sv
/*
 * Self-checking bench for the 8-bit timer with two compare channels.
 * Assumes the bench is both APB master and timer tick source.
 */
module test_timer8_compare_output_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, tick_in, svc_on;
    logic        port_data_a, port_data_b;
    logic [11:0] paddr, ca;
    logic [31:0] pwdata, rdv, mb;
    logic [31:0] seed = 32'h53a5dbf8;
    logic [7:0]  v;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq_ovf, irq_a, irq_b;
    wire         pin_out_a, pin_out_b, timer_active;
    wire  [2:0]  ack;
    int          error_cnt, checks_done;

    tcu_timer8 #(.AW(12)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tick_in(tick_in),
        .irq_ack_ovf(ack[0]), .irq_ack_a(ack[1]), .irq_ack_b(ack[2]),
        .port_data_a(port_data_a), .port_data_b(port_data_b),
        .irq_ovf(irq_ovf), .irq_a(irq_a), .irq_b(irq_b),
        .pin_out_a(pin_out_a), .pin_out_b(pin_out_b),
        .timer_active(timer_active));
    tcu_isr_model #(.DLY(3)) u_isr (.pclk(pclk), .presetn(presetn),
        .svc_on(svc_on), .irq({irq_b, irq_a, irq_ovf}), .ack(ack));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] up(input logic [7:0] c);
        return c + 8'h01;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv & m, e);
    endtask
    task automatic tick();
        @(posedge pclk);
        tick_in <= 1'b1;
        @(posedge pclk);
        tick_in <= 1'b0;
    endtask

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        #400000;
        error_cnt++;
        test_done();
    end
    initial begin
        {presetn, psel, penable, pwrite, tick_in, svc_on} = 6'h0;
        {port_data_a, port_data_b} = 2'h1;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 32; a += 4)
            rd(a[11:0], '1, 32'h0);
        seed = xs(seed);
        v = seed[7:0];
        apb(1'b1, 12'h008, {24'h0, v});
        tick();
        rd(12'h008, '1, {24'h0, v});
        apb(1'b1, 12'h018, 32'h1);
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b1, 12'h008, 32'hff);
        chk({31'h0, timer_active}, 32'h1);
        tick();
        rd(12'h008, '1, {24'h0, up(8'hff)});
        rd(12'h014, '1, 32'h1);
        chk({31'h0, irq_ovf}, 32'h1);
        svc_on <= 1'b1;
        repeat (10) @(posedge pclk);
        rd(12'h014, '1, 32'h0);
        svc_on <= 1'b0;
        for (int ch = 0; ch < 2; ch++) begin
            ca = ch ? 12'h010 : 12'h00c;
            mb = ch ? 32'h4 : 32'h2;
            seed = xs(seed);
            v = seed[7:0] | 8'h02;
            apb(1'b1, ca, {24'h0, v});
            apb(1'b1, 12'h008, {24'h0, v});
            tick();
            rd(12'h014, mb, 32'h0);
            apb(1'b1, 12'h008, {24'h0, v - 8'h01});
            tick();
            tick();
            rd(12'h014, mb, mb);
            apb(1'b1, 12'h018, mb);
            repeat (2) @(posedge pclk);
            chk({29'h0, irq_b, irq_a, 1'b0}, mb);
            apb(1'b1, 12'h014, 32'h0);
            rd(12'h014, mb, mb);
            apb(1'b1, 12'h014, mb);
            rd(12'h014, mb, 32'h0);
        end
        rd(12'h01c, '1, 32'h0);
        seed = xs(seed);
        port_data_a <= seed[0];
        apb(1'b1, 12'h000, 32'h40);
        apb(1'b1, 12'h004, 32'h81);
        rd(12'h004, '1, 32'h1);
        rd(12'h01c, 32'h1, 32'h1);
        chk({31'h0, pin_out_a}, 32'h1);
        rd(12'h014, 32'h2, 32'h0);
        apb(1'b1, 12'h00c, 32'h10);
        apb(1'b1, 12'h000, 32'h03);
        rd(12'h000, '1, 32'h3);
        rd(12'h01c, 32'h1, 32'h1);
        chk({31'h0, pin_out_a}, {31'h0, port_data_a});
        apb(1'b1, 12'h00c, 32'h20);
        rd(12'h00c, '1, 32'h20);
        apb(1'b1, 12'h014, 32'h7);
        apb(1'b1, 12'h008, 32'h0f);
        tick();
        tick();
        rd(12'h014, 32'h2, 32'h2);
        test_done();
    end
endmodule

// file: verilog/tcu_timer8.v
/*
 * 8-bit timer/counter with two compare channels, double-buffered compare
 * values, flags, force strobes, write blocking and port override.
 * Assumes an APB master on pclk and a clock-select enable pulse tick_in.
 */
// Chosen here: the register offsets and the APB register port.
`include "tcu_map.vh"

module tcu_timer8 #(
    parameter AW = 12
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [AW-1:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        tick_in,
    input  wire        irq_ack_ovf,
    input  wire        irq_ack_a,
    input  wire        irq_ack_b,
    input  wire        port_data_a,
    input  wire        port_data_b,
    output reg         irq_ovf,
    output reg         irq_a,
    output reg         irq_b,
    output reg         pin_out_a,
    output reg         pin_out_b,
    output reg         timer_active
);

    reg  [7:0] ctrl_a_r;
    reg  [7:0] ctrl_b_r;
    reg  [7:0] count_r;
    reg  [7:0] cmp_a_r;
    reg  [7:0] cmp_b_r;
    reg  [7:0] buf_a_r;
    reg  [7:0] buf_b_r;
    reg  [2:0] flags_r;
    reg  [2:0] mask_r;
    reg        oc_a_r;
    reg        oc_b_r;
    reg        block_r;
    reg        down_r;
    reg  [7:0] count_nxt;
    reg        down_nxt;

    wire       acc  = psel & penable;
    wire       wr   = acc & pwrite;
    wire [2:0] wgm  = {ctrl_b_r[`TCU_CB_WGM_HI], ctrl_a_r[`TCU_CA_WGM_LO]};
    wire [1:0] com_a = ctrl_a_r[`TCU_CA_COMA];
    wire [1:0] com_b = ctrl_a_r[`TCU_CA_COMB];
    wire       run  = (ctrl_b_r[`TCU_CB_CS] != `TCU_CS_STOP);
    wire       tick = tick_in & run;

    // the undocumented codes 4 and 6 count as in normal mode.
    wire is_fast = (wgm == `TCU_WGM_FAST_MAX) | (wgm == `TCU_WGM_FAST_TOP);
    wire is_pc   = (wgm == `TCU_WGM_PC_MAX) | (wgm == `TCU_WGM_PC_TOP);
    wire is_pwm  = is_fast | is_pc;
    wire top_ocr = (wgm == `TCU_WGM_PC_TOP) | (wgm == `TCU_WGM_FAST_TOP);
    wire [7:0] top = top_ocr ? cmp_a_r : `TCU_MAX;
    wire at_top = (count_r == top);
    wire at_bot = (count_r == `TCU_BOTTOM);

    // comparators run continuously; blocking masks the result.
    wire match_a = (count_r == cmp_a_r) & ~block_r;
    wire match_b = (count_r == cmp_b_r) & ~block_r;

    wire wr_cnt = wr & (paddr == `TCU_ADDR_COUNT);
    wire wr_cb  = wr & (paddr == `TCU_ADDR_CTRL_B);
    wire force_a = wr_cb & pwdata[`TCU_CB_FORCE_A] & ~is_pwm;
    wire force_b = wr_cb & pwdata[`TCU_CB_FORCE_B] & ~is_pwm;

    // Counting direction and next value; mode bits, count, direction and compare A decide this.
    always @* begin
        count_nxt = count_r + 8'h01;
        down_nxt  = down_r;
        if (is_pc) begin
            if (at_top && !down_r) begin
                down_nxt  = 1'b1;
                count_nxt = count_r - 8'h01;
            end else if (at_bot && down_r) begin
                down_nxt  = 1'b0;
            end else if (down_r) begin
                count_nxt = count_r - 8'h01;
            end
        end else begin
            down_nxt = 1'b0;
            if ((wgm == `TCU_WGM_CTC && count_r == cmp_a_r) ||
                (is_fast && at_top)) begin
                count_nxt = `TCU_BOTTOM;
            end
        end
    end

    // Output state update for one channel at a match, a fast PWM wrap or a force.
    function next_oc;
        input       cur;
        input [1:0] com;
        input       pwm;
        input       fast;
        input       dn;
        input       bot;
        input       hit;
        begin
            next_oc = cur;
            if (com != `TCU_COM_OFF) begin
                if (!pwm) begin
                    if (hit) begin
                        case (com)
                            `TCU_COM_TOGGLE: next_oc = ~cur;
                            `TCU_COM_CLEAR:  next_oc = 1'b0;
                            default:         next_oc = 1'b1;
                        endcase
                    end
                end else if (fast) begin
                    if (hit) begin
                        next_oc = (com == `TCU_COM_SET);
                    end else if (bot) begin
                        next_oc = (com != `TCU_COM_SET);
                    end
                end else if (hit) begin
                    next_oc = (com == `TCU_COM_SET) ^ dn;
                end
            end
        end
    endfunction

    // Fast PWM flips polarity when the counter wraps to bottom.
    wire wrap = is_fast & at_top;

    // One overflow event shared by the set and by both clear paths.
    wire ovf_evt = tick & ((!is_pwm && count_r == `TCU_MAX) ||
                           (is_fast && at_top) ||
                           (is_pc && at_bot && down_r));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_r <= 8'h00;
            ctrl_b_r <= 8'h00;
            count_r  <= 8'h00;
            cmp_a_r  <= 8'h00;
            cmp_b_r  <= 8'h00;
            buf_a_r  <= 8'h00;
            buf_b_r  <= 8'h00;
            flags_r  <= 3'h0;
            mask_r   <= 3'h0;
            oc_a_r   <= 1'b0;
            oc_b_r   <= 1'b0;
            block_r  <= 1'b0;
            down_r   <= 1'b0;
        end else begin
            if (wr_cnt) begin
                count_r <= pwdata[7:0];
                block_r <= 1'b1;
            end else if (tick) begin
                count_r <= count_nxt;
                down_r  <= down_nxt;
                block_r <= 1'b0;
            end
            if (tick) begin
                // overflow as the counter leaves MAX or fast top, or turns up at phase-correct bottom.
                if (ovf_evt)
                    flags_r[`TCU_FL_OVF] <= 1'b1;
                if (match_a)
                    flags_r[`TCU_FL_MA] <= 1'b1;
                if (match_b)
                    flags_r[`TCU_FL_MB] <= 1'b1;
                // copy at top for fast, bottom for phase-correct.
                if ((is_fast && at_top) || (is_pc && at_bot)) begin
                    cmp_a_r <= buf_a_r;
                    cmp_b_r <= buf_b_r;
                end
                // mode changes never reset these bits.
                oc_a_r <= next_oc(oc_a_r, com_a, is_pwm, is_fast,
                                  down_r, wrap, match_a);
                oc_b_r <= next_oc(oc_b_r, com_b, is_pwm, is_fast,
                                  down_r, wrap, match_b);
            end
            if (force_a)
                oc_a_r <= next_oc(oc_a_r, com_a, 1'b0, 1'b0,
                                  1'b0, 1'b0, 1'b1);
            if (force_b)
                oc_b_r <= next_oc(oc_b_r, com_b, 1'b0, 1'b0,
                                  1'b0, 1'b0, 1'b1);
            // Clears come after sets in code order and would win, so each clear is gated off when its set fires.
            if (irq_ack_ovf && !ovf_evt)
                flags_r[`TCU_FL_OVF] <= 1'b0;
            if (irq_ack_a && !(tick && match_a))
                flags_r[`TCU_FL_MA] <= 1'b0;
            if (irq_ack_b && !(tick && match_b))
                flags_r[`TCU_FL_MB] <= 1'b0;
            if (wr) begin
                case (paddr)
                    `TCU_ADDR_CTRL_A: ctrl_a_r <= pwdata[7:0];
                    `TCU_ADDR_CTRL_B: ctrl_b_r <= {2'h0, pwdata[5:0]};
                    `TCU_ADDR_CMP_A: begin
                        buf_a_r <= pwdata[7:0];
                        if (!is_pwm)
                            cmp_a_r <= pwdata[7:0];
                    end
                    `TCU_ADDR_CMP_B: begin
                        buf_b_r <= pwdata[7:0];
                        if (!is_pwm)
                            cmp_b_r <= pwdata[7:0];
                    end
                    `TCU_ADDR_FLAGS: begin
                        if (pwdata[`TCU_FL_OVF] && !ovf_evt)
                            flags_r[`TCU_FL_OVF] <= 1'b0;
                        if (pwdata[`TCU_FL_MA] && !(tick && match_a))
                            flags_r[`TCU_FL_MA] <= 1'b0;
                        if (pwdata[`TCU_FL_MB] && !(tick && match_b))
                            flags_r[`TCU_FL_MB] <= 1'b0;
                    end
                    `TCU_ADDR_MASK: mask_r <= pwdata[2:0];
                    default: ;
                endcase
            end
        end
    end

    // Outputs are registered copies; one cycle behind the state above.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata       <= 32'h0000_0000;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            irq_ovf      <= 1'b0;
            irq_a        <= 1'b0;
            irq_b        <= 1'b0;
            pin_out_a    <= 1'b0;
            pin_out_b    <= 1'b0;
            timer_active <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `TCU_ADDR_CTRL_A: prdata <= {24'h0, ctrl_a_r};
                    `TCU_ADDR_CTRL_B: prdata <= {24'h0, ctrl_b_r};
                    `TCU_ADDR_COUNT:  prdata <= {24'h0, count_r};
                    `TCU_ADDR_CMP_A:  prdata <= {24'h0,
                                         is_pwm ? buf_a_r : cmp_a_r};
                    `TCU_ADDR_CMP_B:  prdata <= {24'h0,
                                         is_pwm ? buf_b_r : cmp_b_r};
                    `TCU_ADDR_FLAGS:  prdata <= {29'h0, flags_r};
                    `TCU_ADDR_MASK:   prdata <= {29'h0, mask_r};
                    `TCU_ADDR_OUT:    prdata <= {30'h0, oc_b_r, oc_a_r};
                    default:          prdata <= 32'h0000_0000;
                endcase
            end
            irq_ovf   <= flags_r[`TCU_FL_OVF] & mask_r[`TCU_FL_OVF];
            irq_a     <= flags_r[`TCU_FL_MA] & mask_r[`TCU_FL_MA];
            irq_b     <= flags_r[`TCU_FL_MB] & mask_r[`TCU_FL_MB];
            // direction stays with the port; only data is taken.
            pin_out_a <= (com_a != `TCU_COM_OFF) ? oc_a_r : port_data_a;
            pin_out_b <= (com_b != `TCU_COM_OFF) ? oc_b_r : port_data_b;
            timer_active <= run;
        end
    end

endmodule
